//--- hw/packet_fifo_defines.svh
`ifndef PACKET_FIFO_DEFINES_SVH
`define PACKET_FIFO_DEFINES_SVH
// Summary of operation
// - One 64-byte transmit and one 64-byte receive buffer, one packet each.
// - A new receive packet overwrites whatever the receive buffer still holds.
// - A new transmit packet overwrites too, and raises the transmit access error.
// - Host writes bytes at 0x7C and reads at 0x7F; each write to a non-full or read of a non-empty buffer advances a pointer.
// - An interrupted burst keeps its pointer; the next access resumes there.
// - Host sets transmit length high/low; bit 0 at 0x05 selects one or two bytes.
// - Transmit error on early new packet, write when full, or send when empty.
// - Format A length excludes length and CRC bytes; B and C exclude length only.
// - Received packet length is readable in receive length high/low registers.
// - Read-port select bit 0 at 0x78: 0 reads receive, 1 reads transmit buffer.
// - A read-only usage register shows occupied receive bytes.
// - Receive access error on overrun or on reading an empty receive buffer.
// - Full event when transmit usage exceeds the transmit full threshold.
// - Empty event when transmit usage falls below the transmit empty threshold.
// - Transmit full state clears below full level; empty state clears at empty level.
// - Receive full and empty states clear and re-arm the same way.
// - Receive full above full threshold; empty when reads drop below empty threshold.
// - Receive thresholds act only during reception; no empty event after it.

// =============================================================
// Register offsets
`define OFF_PACKET_CONTROL_TWO 8'h05
`define OFF_STATE_CLEAR 8'h16
`define OFF_TX_FULL_THR 8'h17
`define OFF_TX_EMPTY_THR 8'h18
`define OFF_RX_FULL_THR 8'h19
`define OFF_RX_EMPTY_THR 8'h1A
`define OFF_READ_SEL 8'h78
`define OFF_RX_USAGE 8'h79
`define OFF_TX_LEN_HI 8'h7A
`define OFF_TX_LEN_LO 8'h7B
`define OFF_TX_WRITE 8'h7C
`define OFF_RX_LEN_HI 8'h7D
`define OFF_RX_LEN_LO 8'h7E
`define OFF_READ_PORT 8'h7F

// =============================================================
// Field positions
`define BIT_LENGTH_MODE 0
`define BIT_TX_PTR_CLR 0
`define BIT_RX_PTR_CLR 1
`define BIT_READ_SEL 0

// =============================================================
// Reset values and sizes
`define RST_THRESHOLD 8'h00
`define RST_BYTE 8'h00
`define BUF_DEPTH 64
`define BUF_WIDTH 8
`endif

//--- hw/packet_fifo_pkg.sv
package packet_fifo_pkg;
	// Register access as the SPI decoder presents it
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// One-cycle event pulses toward the interrupt groups
	typedef struct packed {
		logic tx_err;
		logic rx_err;
		logic full;
		logic empty;
	} buf_events_t;

	typedef struct packed {
		logic [7:0] tx_full_thr;
		logic [7:0] tx_empty_thr;
		logic [7:0] rx_full_thr;
		logic [7:0] rx_empty_thr;
		logic read_sel;
		logic length_mode;
		logic [7:0] tx_len_hi;
		logic [7:0] tx_len_lo;
		logic [7:0] rx_len_hi;
		logic [7:0] rx_len_lo;
		logic [7:0] rdata;
		logic tx_full_det;
		logic tx_empty_det;
		logic rx_full_det;
		logic rx_empty_det;
		buf_events_t events;
	} ctrl_state_t;
endpackage : packet_fifo_pkg

//--- hw/byte_fifo.sv
`timescale 1ns/1ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clr,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// Occupancy
	output logic [$clog2(DEPTH+1)-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("byte_fifo depth must be a power of two");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
	} fifo_state_t;

	fifo_state_t s_q, s_d;
	logic push, pop;

	assign in_ready = s_q.cnt != CW'(DEPTH);
	assign out_valid = s_q.cnt != '0;
	assign out_data = s_q.mem[s_q.rp];
	assign count = s_q.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		s_d = s_q;
		// Pointers persist between bursts; only clr and rst rewind them
		if (clr) begin
			s_d.wp = '0;
			s_d.rp = '0;
			s_d.cnt = '0;
		end else begin
			if (push) begin
				s_d.mem[s_q.wp] = in_data;
				s_d.wp = s_q.wp + AW'(1);
			end
			if (pop) begin
				s_d.rp = s_q.rp + AW'(1);
			end
			s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : byte_fifo

//--- hw/packet_fifo_threshold_control.sv
`timescale 1ns/1ps
`include "packet_fifo_defines.svh"
module packet_fifo_threshold_control
	import packet_fifo_pkg::*;
#(
	parameter int DEPTH = `BUF_DEPTH
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register access
	input wire reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	// Transmit side toward the modem
	output logic tx_byte_valid,
	input wire logic tx_byte_ready,
	output logic [7:0] tx_byte,
	input wire logic tx_start,
	output logic [15:0] tx_length,
	// Receive side from the modem
	input wire logic rx_byte_valid,
	output logic rx_byte_ready,
	input wire logic [7:0] rx_byte,
	input wire logic rx_pkt_start,
	input wire logic rx_active,
	input wire logic rx_len_valid,
	input wire logic [15:0] rx_len,
	// Interrupt events
	output buf_events_t events
);
	localparam int CW = $clog2(DEPTH+1);

	if (DEPTH > 255) begin : g_chk
		$error("usage must fit the 8-bit usage register");
	end

	// =============================================================
	// Threshold detector step: {new state, one-shot event}
	function automatic logic [1:0] det_step(input logic det, input logic set_c,
		input logic clr_c);
		logic fire;
		fire = !det && set_c;
		return {fire || (det && !clr_c), fire};
	endfunction : det_step

	ctrl_state_t s_q, s_d;

	logic [CW-1:0] tx_cnt, rx_cnt;
	logic [7:0] tx_head, rx_head;
	logic tx_in_ready, rx_in_ready, tx_out_valid, rx_out_valid;
	logic wr, rd, tx_wr, port_rd, host_tx_pop, host_rx_pop;
	logic tx_overwrite, rx_overwrite, tx_clr, rx_clr;
	logic [7:0] tx_use, rx_use;
	logic [1:0] tx_f, tx_e, rx_f, rx_e;

	// =============================================================
	// Access decode
	assign wr = reg_req.wr;
	assign rd = reg_req.rd;
	assign tx_wr = wr && reg_req.addr == `OFF_TX_WRITE;
	assign port_rd = rd && reg_req.addr == `OFF_READ_PORT;
	assign host_rx_pop = port_rd && !s_q.read_sel;
	assign host_tx_pop = port_rd && s_q.read_sel;

	// A fresh low length byte write marks a new packet; leftovers are dropped
	assign tx_overwrite = wr && reg_req.addr == `OFF_TX_LEN_LO && tx_cnt != '0;
	assign rx_overwrite = rx_pkt_start && rx_cnt != '0;
	assign tx_clr = tx_overwrite ||
		(wr && reg_req.addr == `OFF_STATE_CLEAR && reg_req.wdata[`BIT_TX_PTR_CLR]);
	assign rx_clr = rx_overwrite ||
		(wr && reg_req.addr == `OFF_STATE_CLEAR && reg_req.wdata[`BIT_RX_PTR_CLR]);

	// =============================================================
	// Buffers, one packet each
	byte_fifo #(.WIDTH(`BUF_WIDTH), .DEPTH(DEPTH)) u_tx_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.clr(tx_clr),
		.in_valid(tx_wr),
		.in_ready(tx_in_ready),
		.in_data(reg_req.wdata),
		.out_valid(tx_out_valid),
		.out_ready(tx_byte_ready || host_tx_pop),
		.out_data(tx_head),
		.count(tx_cnt)
	);

	byte_fifo #(.WIDTH(`BUF_WIDTH), .DEPTH(DEPTH)) u_rx_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.clr(rx_clr),
		.in_valid(rx_byte_valid),
		.in_ready(rx_in_ready),
		.in_data(rx_byte),
		.out_valid(rx_out_valid),
		.out_ready(host_rx_pop),
		.out_data(rx_head),
		.count(rx_cnt)
	);

	// Host readback of the transmit buffer takes priority over the modem
	assign tx_byte_valid = tx_out_valid && !host_tx_pop;
	assign tx_byte = tx_head;
	assign rx_byte_ready = rx_in_ready;

	// One-byte length sends only the low byte
	assign tx_length = s_q.length_mode ? {s_q.tx_len_hi, s_q.tx_len_lo}
		: {8'h00, s_q.tx_len_lo};
	assign reg_rdata = s_q.rdata;
	assign events = s_q.events;

	assign tx_use = 8'(tx_cnt);
	assign rx_use = 8'(rx_cnt);

	// =============================================================
	// Threshold detectors
	assign tx_f = det_step(s_q.tx_full_det, tx_use > s_q.tx_full_thr,
		tx_use < s_q.tx_full_thr);
	assign tx_e = det_step(s_q.tx_empty_det, tx_use < s_q.tx_empty_thr,
		tx_use >= s_q.tx_empty_thr);
	assign rx_f = det_step(s_q.rx_full_det, rx_use > s_q.rx_full_thr,
		rx_use < s_q.rx_full_thr);
	assign rx_e = det_step(s_q.rx_empty_det, rx_use < s_q.rx_empty_thr,
		rx_use >= s_q.rx_empty_thr);

	// =============================================================
	// Next state
	always_comb begin
		s_d = s_q;
		// Register writes
		if (wr) begin
			case (reg_req.addr)
				`OFF_PACKET_CONTROL_TWO:
					s_d.length_mode = reg_req.wdata[`BIT_LENGTH_MODE];
				`OFF_TX_FULL_THR: s_d.tx_full_thr = reg_req.wdata;
				`OFF_TX_EMPTY_THR: s_d.tx_empty_thr = reg_req.wdata;
				`OFF_RX_FULL_THR: s_d.rx_full_thr = reg_req.wdata;
				`OFF_RX_EMPTY_THR: s_d.rx_empty_thr = reg_req.wdata;
				`OFF_READ_SEL: s_d.read_sel = reg_req.wdata[`BIT_READ_SEL];
				`OFF_TX_LEN_HI: s_d.tx_len_hi = reg_req.wdata;
				`OFF_TX_LEN_LO: s_d.tx_len_lo = reg_req.wdata;
				default: ;
			endcase
		end
		// Received length captured for the host
		if (rx_len_valid) begin
			s_d.rx_len_hi = rx_len[15:8];
			s_d.rx_len_lo = rx_len[7:0];
		end
		// Register reads, answered one cycle later
		if (rd) begin
			case (reg_req.addr)
				`OFF_PACKET_CONTROL_TWO: s_d.rdata = {7'h00, s_q.length_mode};
				`OFF_TX_FULL_THR: s_d.rdata = s_q.tx_full_thr;
				`OFF_TX_EMPTY_THR: s_d.rdata = s_q.tx_empty_thr;
				`OFF_RX_FULL_THR: s_d.rdata = s_q.rx_full_thr;
				`OFF_RX_EMPTY_THR: s_d.rdata = s_q.rx_empty_thr;
				`OFF_READ_SEL: s_d.rdata = {7'h00, s_q.read_sel};
				`OFF_RX_USAGE: s_d.rdata = rx_use;
				`OFF_TX_LEN_HI: s_d.rdata = s_q.tx_len_hi;
				`OFF_TX_LEN_LO: s_d.rdata = s_q.tx_len_lo;
				`OFF_RX_LEN_HI: s_d.rdata = s_q.rx_len_hi;
				`OFF_RX_LEN_LO: s_d.rdata = s_q.rx_len_lo;
				`OFF_READ_PORT: s_d.rdata = s_q.read_sel ? (tx_out_valid ? tx_head : 8'h00)
					: (rx_out_valid ? rx_head : 8'h00);
				default: s_d.rdata = 8'h00;
			endcase
		end
		// Access errors
		s_d.events.tx_err = tx_overwrite || (tx_wr && !tx_in_ready) ||
			(tx_start && tx_cnt == '0);
		s_d.events.rx_err = (rx_byte_valid && !rx_in_ready) ||
			(host_rx_pop && !rx_out_valid);
		// Transmit detectors always run
		s_d.tx_full_det = tx_f[1];
		s_d.tx_empty_det = tx_e[1];
		// Receive detectors frozen outside reception
		if (rx_active) begin
			s_d.rx_full_det = rx_f[1];
			s_d.rx_empty_det = rx_e[1];
		end
		// One pulse per detection, never a level
		s_d.events.full = tx_f[0] || (rx_active && rx_f[0]);
		s_d.events.empty = tx_e[0] || (rx_active && rx_e[0]);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.tx_full_thr <= `RST_THRESHOLD;
			s_q.tx_empty_thr <= `RST_THRESHOLD;
			s_q.rx_full_thr <= `RST_THRESHOLD;
			s_q.rx_empty_thr <= `RST_THRESHOLD;
			s_q.rdata <= `RST_BYTE;
		end else begin
			s_q <= s_d;
		end
	end

	// =============================================================
	// Assertions
	sequence s_tx_full_write;
		tx_wr && !tx_in_ready && !tx_clr;
	endsequence

	sequence s_tx_err_pulse;
		events.tx_err;
	endsequence

	property p_tx_overrun;
		@(posedge sys_clk) disable iff (rst)
		s_tx_full_write |=> s_tx_err_pulse;
	endproperty
	a_tx_overrun: assert property (p_tx_overrun)
		else $error("tx write on full buffer gave no error");

	property p_tx_underrun;
		@(posedge sys_clk) disable iff (rst)
		tx_start && tx_cnt == '0 |=> events.tx_err;
	endproperty
	a_tx_underrun: assert property (p_tx_underrun)
		else $error("tx start on empty buffer gave no error");

	property p_tx_overwrite;
		@(posedge sys_clk) disable iff (rst)
		tx_overwrite |=> events.tx_err && tx_cnt == '0;
	endproperty
	a_tx_overwrite: assert property (p_tx_overwrite)
		else $error("tx new packet did not flush and flag");

	property p_rx_overwrite;
		@(posedge sys_clk) disable iff (rst)
		rx_pkt_start && rx_cnt != '0 |=> rx_cnt == '0;
	endproperty
	a_rx_overwrite: assert property (p_rx_overwrite)
		else $error("rx new packet did not overwrite");

	property p_rx_error;
		@(posedge sys_clk) disable iff (rst)
		(rx_byte_valid && rx_cnt == CW'(DEPTH)) ||
		(port_rd && !s_q.read_sel && rx_cnt == '0) |=> events.rx_err;
	endproperty
	a_rx_error: assert property (p_rx_error)
		else $error("rx overrun or underrun not flagged");

	property p_length_mode;
		@(posedge sys_clk) disable iff (rst)
		!s_q.length_mode |-> tx_length[15:8] == 8'h00;
	endproperty
	a_length_mode: assert property (p_length_mode)
		else $error("one-byte length leaked high byte");

	property p_usage_read;
		@(posedge sys_clk) disable iff (rst)
		rd && reg_req.addr == `OFF_RX_USAGE |=> reg_rdata == $past(rx_use);
	endproperty
	a_usage_read: assert property (p_usage_read)
		else $error("usage register wrong");

	property p_pointer_kept;
		@(posedge sys_clk) disable iff (rst)
		!tx_wr && !tx_clr && !tx_byte_ready && !host_tx_pop ##1 1 |-> $stable(tx_cnt);
	endproperty
	a_pointer_kept: assert property (p_pointer_kept)
		else $error("tx pointer moved without access");

	property p_full_once;
		@(posedge sys_clk) disable iff (rst)
		events.full |-> (s_q.tx_full_det && !$past(s_q.tx_full_det)) ||
			(s_q.rx_full_det && !$past(s_q.rx_full_det));
	endproperty
	a_full_once: assert property (p_full_once)
		else $error("full event without new detection");

	property p_rx_empty_gate;
		@(posedge sys_clk) disable iff (rst)
		events.empty && !(s_q.tx_empty_det && !$past(s_q.tx_empty_det)) |->
			$past(rx_active);
	endproperty
	a_rx_empty_gate: assert property (p_rx_empty_gate)
		else $error("rx empty event outside reception");

	property p_tx_full_fire;
		@(posedge sys_clk) disable iff (rst)
		!s_q.tx_full_det && tx_use > s_q.tx_full_thr |=> events.full && s_q.tx_full_det;
	endproperty
	a_tx_full_fire: assert property (p_tx_full_fire)
		else $error("tx full threshold missed");

	property p_tx_empty_fire;
		@(posedge sys_clk) disable iff (rst)
		!s_q.tx_empty_det && tx_use < s_q.tx_empty_thr |=> events.empty;
	endproperty
	a_tx_empty_fire: assert property (p_tx_empty_fire)
		else $error("tx empty threshold missed");

	property p_tx_full_rearm;
		@(posedge sys_clk) disable iff (rst)
		s_q.tx_full_det && tx_use < s_q.tx_full_thr |=> !s_q.tx_full_det;
	endproperty
	a_tx_full_rearm: assert property (p_tx_full_rearm)
		else $error("tx full state not re-armed");

	property p_rx_full_rearm;
		@(posedge sys_clk) disable iff (rst)
		rx_active && s_q.rx_full_det && rx_use < s_q.rx_full_thr |=> !s_q.rx_full_det;
	endproperty
	a_rx_full_rearm: assert property (p_rx_full_rearm)
		else $error("rx full state not re-armed");

	property p_rx_full_fire;
		@(posedge sys_clk) disable iff (rst)
		rx_active && !s_q.rx_full_det && rx_use > s_q.rx_full_thr |=> events.full;
	endproperty
	a_rx_full_fire: assert property (p_rx_full_fire)
		else $error("rx full threshold missed");

	property p_rx_len;
		@(posedge sys_clk) disable iff (rst)
		rx_len_valid |=> {s_q.rx_len_hi, s_q.rx_len_lo} == $past(rx_len);
	endproperty
	a_rx_len: assert property (p_rx_len)
		else $error("rx length not captured");

	property p_read_sel;
		@(posedge sys_clk) disable iff (rst)
		port_rd && s_q.read_sel && tx_out_valid |=> reg_rdata == $past(tx_head);
	endproperty
	a_read_sel: assert property (p_read_sel)
		else $error("read port ignored select");

	property p_tx_empty_rearm;
		@(posedge sys_clk) disable iff (rst)
		s_q.tx_empty_det && tx_use >= s_q.tx_empty_thr |=> !s_q.tx_empty_det;
	endproperty
	a_tx_empty_rearm: assert property (p_tx_empty_rearm)
		else $error("tx empty state not re-armed");

	property p_rx_empty_fire;
		@(posedge sys_clk) disable iff (rst)
		rx_active && !s_q.rx_empty_det && rx_use < s_q.rx_empty_thr |=> events.empty;
	endproperty
	a_rx_empty_fire: assert property (p_rx_empty_fire)
		else $error("rx empty threshold missed");

	property p_rx_frozen;
		@(posedge sys_clk) disable iff (rst)
		!rx_active |=> $stable(s_q.rx_full_det) && $stable(s_q.rx_empty_det);
	endproperty
	a_rx_frozen: assert property (p_rx_frozen)
		else $error("rx detector moved outside reception");
endmodule : packet_fifo_threshold_control

//--- sim/modem_model.sv
`timescale 1ns/1ps
module modem_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Transmit side
	input wire logic tx_byte_valid,
	output logic tx_byte_ready,
	input wire logic [7:0] tx_byte,
	output logic tx_start,
	// Receive side
	output logic rx_byte_valid,
	input wire logic rx_byte_ready,
	output logic [7:0] rx_byte,
	output logic rx_pkt_start,
	output logic rx_active,
	output logic rx_len_valid,
	output logic [15:0] rx_len
);
	logic take_en = 1'b0;
	logic [7:0] got_q[$];
	int phase = 0;
	initial begin
		tx_byte_ready = 1'b0;
		tx_start = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		rx_pkt_start = 1'b0;
		rx_active = 1'b0;
		rx_len_valid = 1'b0;
		rx_len = 16'h0000;
	end
	// =========================================
	// Transmit drain, stalls every third cycle
	always @(negedge sys_clk) begin
		phase <= phase + 1;
		tx_byte_ready <= take_en && (phase % 3 != 0);
	end
	always @(posedge sys_clk) begin
		if (rst === 1'b0 && tx_byte_valid === 1'b1 && tx_byte_ready) begin
			got_q.push_back(tx_byte);
		end
	end
	task automatic kick_tx();
		@(negedge sys_clk);
		tx_start = 1'b1;
		@(negedge sys_clk);
		tx_start = 1'b0;
	endtask : kick_tx
	// =========================================
	// Receive packet; sends even when full, on purpose
	task automatic send_rx(input int n, input logic [7:0] first, input logic keep);
		@(negedge sys_clk);
		rx_active = 1'b1;
		rx_pkt_start = 1'b1;
		rx_len_valid = 1'b1;
		rx_len = 16'(n);
		@(negedge sys_clk);
		rx_pkt_start = 1'b0;
		rx_len_valid = 1'b0;
		for (int i = 0; i < n; i++) begin
			rx_byte = first + 8'(i);
			rx_byte_valid = 1'b1;
			@(negedge sys_clk);
			rx_byte_valid = 1'b0;
			// No hold on the data line, so never leave the last value
			rx_byte = ~rx_byte;
			@(negedge sys_clk);
		end
		rx_active = keep;
	endtask : send_rx
endmodule : modem_model

//--- sim/tb.sv
`timescale 1ns/1ps
module tb
	import packet_fifo_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst;
	reg_req_t reg_req;
	logic [7:0] reg_rdata, tx_byte, rx_byte;
	logic tx_byte_valid, tx_byte_ready, tx_start, rx_byte_valid, rx_byte_ready;
	logic rx_pkt_start, rx_active, rx_len_valid;
	logic [15:0] tx_length, rx_len;
	buf_events_t events;
	int bad_count = 0;
	int tests_run = 0;
	int cycles = 0;
	int ev[4] = '{0, 0, 0, 0};
	int base[4];
	logic [31:0] lfsr_q = 32'h0000_506d;
	logic [7:0] zero_addrs[12] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h78, 8'h79,
		8'h7A, 8'h7B, 8'h7D, 8'h7E, 8'h16, 8'h40};

	always #2.5 sys_clk = ~sys_clk;

	packet_fifo_threshold_control #(.DEPTH(64)) i_dut (.sys_clk(sys_clk), .rst(rst),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .tx_byte_valid(tx_byte_valid),
		.tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte), .tx_start(tx_start),
		.tx_length(tx_length), .rx_byte_valid(rx_byte_valid),
		.rx_byte_ready(rx_byte_ready), .rx_byte(rx_byte), .rx_pkt_start(rx_pkt_start),
		.rx_active(rx_active), .rx_len_valid(rx_len_valid), .rx_len(rx_len),
		.events(events));
	modem_model i_modem (.sys_clk(sys_clk), .rst(rst), .tx_byte_valid(tx_byte_valid),
		.tx_byte_ready(tx_byte_ready), .tx_byte(tx_byte), .tx_start(tx_start),
		.rx_byte_valid(rx_byte_valid), .rx_byte_ready(rx_byte_ready),
		.rx_byte(rx_byte), .rx_pkt_start(rx_pkt_start), .rx_active(rx_active),
		.rx_len_valid(rx_len_valid), .rx_len(rx_len));

	// =========================================
	// Event counters and hang guard
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (rst === 1'b0) begin
			ev[0] <= ev[0] + int'(events.tx_err === 1'b1);
			ev[1] <= ev[1] + int'(events.rx_err === 1'b1);
			ev[2] <= ev[2] + int'(events.full === 1'b1);
			ev[3] <= ev[3] + int'(events.empty === 1'b1);
		end
		if (cycles == 20000) begin
			bad_count++;
			$display("BAD t=%0t run hung", $time);
			tally_and_finish();
		end
	end

	// =========================================
	// Helpers
	function automatic logic [7:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q[7:0];
	endfunction : rnd
	function automatic logic [15:0] exp_len(input logic m, input logic [7:0] h, l);
		return m ? {h, l} : {8'h00, l};
	endfunction : exp_len
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge sys_clk);
		reg_req.wr = 1'b0;
	endtask : reg_wr
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : check_val
	task automatic expect_rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge sys_clk);
		reg_req.rd = 1'b0;
		check_val(16'(reg_rdata), 16'(exp));
	endtask : expect_rd
	task automatic check_ev(input int i, input int exp);
		tests_run++;
		if (ev[i] - base[i] != exp) begin
			bad_count++;
			$display("BAD t=%0t event %0d count %0d expected %0d", $time, i,
				ev[i] - base[i], exp);
		end
	endtask : check_ev
	task automatic settle();
		repeat (3) @(negedge sys_clk);
	endtask : settle
	task automatic snap();
		settle();
		base = ev;
	endtask : snap
	task automatic drain(input int n);
		i_modem.got_q.delete();
		i_modem.take_en = 1'b1;
		for (int k = 0; k < 600 && i_modem.got_q.size() < n; k++) @(negedge sys_clk);
		i_modem.take_en = 1'b0;
		check_val(16'(i_modem.got_q.size()), 16'(n));
		settle();
	endtask : drain
	task automatic fill(input int n);
		for (int i = 0; i < n; i++) reg_wr(8'h7C, rnd());
		settle();
	endtask : fill
	task automatic done_test(input string name);
		$display("test %s done, mismatches so far %0d", name, bad_count);
	endtask : done_test
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : tally_and_finish

	// =========================================
	// Main sequence
	initial begin
		logic [7:0] d, hi, lo, f;
		logic [7:0] expq[$];
		reg_req = '0;
		rst = 1'b1;
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
		foreach (zero_addrs[i]) expect_rd(zero_addrs[i], 8'h00);
		check_val(tx_length, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			reg_wr(8'h17 + 8'(i), d);
			expect_rd(8'h17 + 8'(i), d);
		end
		for (int m = 0; m < 2; m++) begin
			hi = rnd();
			lo = rnd();
			reg_wr(8'h05, 8'(m));
			reg_wr(8'h7A, hi);
			reg_wr(8'h7B, lo);
			check_val(tx_length, exp_len(m[0], hi, lo));
			expect_rd(8'h7B, lo);
		end
		done_test("registers");
		// Overfill by one, then drain with stalls, then start while empty
		snap();
		for (int i = 0; i < 64; i++) begin
			d = rnd();
			expq.push_back(d);
			reg_wr(8'h7C, d);
		end
		reg_wr(8'h7C, 8'h5A);
		drain(64);
		foreach (expq[i]) check_val(16'(i_modem.got_q[i]), 16'(expq[i]));
		i_modem.kick_tx();
		settle();
		check_ev(0, 2);
		// New packet over a held one, then readback through the read port
		reg_wr(8'h78, 8'h01);
		fill(5);
		snap();
		reg_wr(8'h7B, 8'h05);
		settle();
		check_ev(0, 1);
		expect_rd(8'h7F, 8'h00);
		fill(2);
		reg_wr(8'h16, 8'h01);
		reg_wr(8'h7C, 8'hA1);
		reg_wr(8'h7C, 8'hA2);
		expect_rd(8'h7F, 8'hA1);
		expect_rd(8'h7B, 8'h05);
		expect_rd(8'h7F, 8'hA2);
		done_test("transmit");
		// Receive, interrupted burst, underrun
		reg_wr(8'h78, 8'h00);
		f = rnd();
		i_modem.send_rx(20, f, 1'b0);
		expect_rd(8'h7D, 8'h00);
		expect_rd(8'h7E, 8'd20);
		expect_rd(8'h79, 8'd20);
		for (int i = 0; i < 7; i++) expect_rd(8'h7F, f + 8'(i));
		expect_rd(8'h79, 8'd13);
		for (int i = 7; i < 20; i++) expect_rd(8'h7F, f + 8'(i));
		snap();
		expect_rd(8'h7F, 8'h00);
		settle();
		check_ev(1, 1);
		i_modem.send_rx(5, 8'h10, 1'b0);
		i_modem.send_rx(6, 8'h80, 1'b0);
		expect_rd(8'h79, 8'd6);
		expect_rd(8'h7F, 8'h80);
		reg_wr(8'h16, 8'h02);
		expect_rd(8'h79, 8'h00);
		snap();
		i_modem.send_rx(65, 8'h00, 1'b0);
		settle();
		check_ev(1, 1);
		expect_rd(8'h79, 8'd64);
		check_val(16'(rx_byte_ready), 16'h0000);
		reg_wr(8'h16, 8'h02);
		done_test("receive");
		// Transmit thresholds, full above empty, rearm after each clear
		reg_wr(8'h17, 8'd10);
		reg_wr(8'h18, 8'd4);
		for (int r = 1; r < 3; r++) begin
			snap();
			fill(11);
			repeat (20) @(negedge sys_clk);
			check_ev(2, 1);
			check_ev(3, 0);
			drain(11);
			check_ev(2, 1);
			check_ev(3, 1);
		end
		reg_wr(8'h17, 8'hFF);
		reg_wr(8'h18, 8'h00);
		done_test("tx thresholds");
		// Receive thresholds only act while a packet is coming in
		reg_wr(8'h19, 8'd8);
		reg_wr(8'h1A, 8'd3);
		snap();
		i_modem.send_rx(10, 8'h20, 1'b1);
		settle();
		check_ev(2, 1);
		snap();
		for (int i = 0; i < 8; i++) expect_rd(8'h7F, 8'h20 + 8'(i));
		settle();
		check_ev(3, 1);
		check_ev(2, 0);
		i_modem.send_rx(10, 8'h40, 1'b0);
		snap();
		for (int i = 0; i < 10; i++) expect_rd(8'h7F, 8'h40 + 8'(i));
		settle();
		check_ev(3, 0);
		done_test("rx thresholds");
		tally_and_finish();
	end
endmodule : tb
